/* design/dvo_pkg.sv */
// constants and types shared by the divider square-wave output block
package dvo_pkg;
	localparam int          HADDR_W        = 8;
	localparam logic [7:0]  ADDR_CONTROL   = 8'h38;
	localparam logic [7:0]  ADDR_SOURCE    = 8'h3C;
	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam int          EN_BIT         = 2;
	localparam int          SEL_LSB        = 0;
	localparam int          SEL_W          = 2;
	localparam int          PRESCALE_BIT   = 0;
	localparam logic [1:0]  SEL_RESERVED   = 2'h3;
	localparam int          GEAR_CHAIN_W   = 12;
	localparam int          LOW_CHAIN_W    = 5;
	localparam logic [3:0]  GEAR_TOP_TAP   = 4'hB;
	localparam logic [2:0]  LOW_TOP_TAP    = 3'h4;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_IDLE,
		MODE_SLOW,
		MODE_SLOW_SLEEP,
		MODE_STOP,
		MODE_DEEP_IDLE,
		MODE_DEEP_SLEEP
	} dvo_mode_t;
endpackage : dvo_pkg

/* design/dvo_div_chain.sv */
// free-running divider chains for the gear clock and the low-frequency clock
`timescale 1ns/1ps
module dvo_div_chain (
	input  wire logic                            i_clk_sys,
	input  wire logic                            i_rst,
	input  wire logic                            i_gear_tick,
	input  wire logic                            i_low_tick,
	output logic [dvo_pkg::GEAR_CHAIN_W-1:0]     o_gear_cnt,
	output logic [dvo_pkg::LOW_CHAIN_W-1:0]      o_low_cnt
);
	// R7: chain runs always
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_gear_cnt <= '0;
		end else if (i_gear_tick) begin
			o_gear_cnt <= o_gear_cnt + 1'b1;
		end
	end

	// R5: low chain on gear-synchronous ticks, hence period jitter
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_low_cnt <= '0;
		end else if (i_low_tick) begin
			o_low_cnt <= o_low_cnt + 1'b1;
		end
	end
endmodule : dvo_div_chain

/* design/dvo_top.sv */
// divider square-wave output: ahb-lite registers, source select and output pin
//
// What this block does
// R1: while enabled, pin carries the selected square wave at about half duty.
// R2: with enable at zero the active-low pin stays high.
// R3: select picks gear/2^12..2^9, or low clock/2^5..2^3 with code 11 reserved.
// R4: entering stop, deep idle or deep sleep clears enable; select kept.
// R5: low clock used in normal or idle modes may show period jitter.
// R6: control register bits 7 to 3 read as zero.
// R7: divider chain runs regardless of enable; first period may be short.
// R8: clearing enable cuts the last period short.
// R9: software clear of enable stops the output, pin high one clock edge after enable clears, not at once.
// R10: normal/slow switches may disturb the frequency while clocks resync.
// R11: reserved select code on the current source keeps the pin high.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dvo_top (
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_rst,
	input  wire logic                          i_hsel,
	input  wire logic [dvo_pkg::HADDR_W-1:0]   i_haddr,
	input  wire logic [1:0]                    i_htrans,
	input  wire logic                          i_hwrite,
	input  wire logic [2:0]                    i_hsize,
	input  wire logic [31:0]                   i_hwdata,
	input  wire logic                          i_hready,
	output logic [31:0]                        o_hrdata,
	output logic                               o_hreadyout,
	output logic                               o_hresp,
	input  wire logic                          i_gear_tick,
	input  wire logic                          i_low_freq_tick,
	input  wire dvo_pkg::dvo_mode_t            i_op_mode,
	output logic                               o_divider_out_pin_n
);
	logic                                 wr_pend_r;
	logic [dvo_pkg::HADDR_W-1:0]          wr_addr_r;
	logic                                 divout_enable_r;
	logic [dvo_pkg::SEL_W-1:0]            divout_freq_sel_r;
	logic                                 low_clk_prescale_sel_r;
	dvo_pkg::dvo_mode_t                   mode_prev_r;
	logic [dvo_pkg::GEAR_CHAIN_W-1:0]     gear_cnt;
	logic [dvo_pkg::LOW_CHAIN_W-1:0]      low_cnt;
	logic                                 addr_phase;
	logic                                 wr_ctrl;
	logic                                 wr_src;
	logic                                 deep_now;
	logic                                 deep_prev;
	logic                                 deep_entry;
	logic                                 use_low;
	logic                                 sel_reserved;
	logic                                 tap;
	logic [7:0]                           ctrl_view;
	logic [7:0]                           ctrl_fwd;
	logic                                 src_fwd;
	logic [3:0]                           gear_idx;
	logic [2:0]                           low_idx;

	dvo_div_chain u_chain (
		.i_clk_sys  (i_clk_sys),
		.i_rst      (i_rst),
		.i_gear_tick(i_gear_tick),
		.i_low_tick (i_low_freq_tick),
		.o_gear_cnt (gear_cnt),
		.o_low_cnt  (low_cnt)
	);

	// zero-wait slave: every transfer completes in its first data-phase cycle
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	assign addr_phase  = i_hsel & i_hready & (i_htrans == dvo_pkg::HTRANS_NONSEQ);
	assign wr_ctrl     = wr_pend_r & (wr_addr_r == dvo_pkg::ADDR_CONTROL);
	assign wr_src      = wr_pend_r & (wr_addr_r == dvo_pkg::ADDR_SOURCE);

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else begin
			wr_pend_r <= addr_phase & i_hwrite;
			if (addr_phase) begin
				wr_addr_r <= i_haddr;
			end
		end
	end

	function automatic logic is_deep(input dvo_pkg::dvo_mode_t m);
		is_deep = (m == dvo_pkg::MODE_STOP) || (m == dvo_pkg::MODE_DEEP_IDLE) ||
			(m == dvo_pkg::MODE_DEEP_SLEEP);
	endfunction : is_deep

	assign deep_now   = is_deep(i_op_mode);
	assign deep_prev  = is_deep(mode_prev_r);
	assign deep_entry = deep_now & ~deep_prev;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			mode_prev_r <= dvo_pkg::MODE_NORMAL;
		end else begin
			mode_prev_r <= i_op_mode;
		end
	end

	// R4: mode entry clears enable and wins over a write
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			divout_enable_r <= dvo_pkg::CONTROL_RESET[dvo_pkg::EN_BIT];
		end else if (deep_entry) begin
			divout_enable_r <= 1'b0;
		end else if (wr_ctrl) begin
			divout_enable_r <= i_hwdata[dvo_pkg::EN_BIT];
		end
	end

	// R4: select field survives the low-power entry
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			divout_freq_sel_r <= dvo_pkg::CONTROL_RESET[dvo_pkg::SEL_LSB +: dvo_pkg::SEL_W];
		end else if (wr_ctrl) begin
			divout_freq_sel_r <= i_hwdata[dvo_pkg::SEL_LSB +: dvo_pkg::SEL_W];
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			low_clk_prescale_sel_r <= 1'b0;
		end else if (wr_src) begin
			low_clk_prescale_sel_r <= i_hwdata[dvo_pkg::PRESCALE_BIT];
		end
	end

	// R6: upper control bits read as zero
	always_comb begin
		ctrl_view = '0;
		ctrl_view[dvo_pkg::EN_BIT] = divout_enable_r;
		ctrl_view[dvo_pkg::SEL_LSB +: dvo_pkg::SEL_W] = divout_freq_sel_r;
	end

	// a write in its data phase is forwarded so a following read sees it
	always_comb begin
		ctrl_fwd = ctrl_view;
		if (wr_ctrl) begin
			ctrl_fwd[dvo_pkg::EN_BIT] = i_hwdata[dvo_pkg::EN_BIT] & ~deep_entry;
			ctrl_fwd[dvo_pkg::SEL_LSB +: dvo_pkg::SEL_W] = i_hwdata[dvo_pkg::SEL_LSB +: dvo_pkg::SEL_W];
		end
		src_fwd = wr_src ? i_hwdata[dvo_pkg::PRESCALE_BIT] : low_clk_prescale_sel_r;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_hrdata <= '0;
		end else if (addr_phase & ~i_hwrite) begin
			if (i_haddr == dvo_pkg::ADDR_CONTROL) begin
				o_hrdata <= {24'h000000, ctrl_fwd};
			end else if (i_haddr == dvo_pkg::ADDR_SOURCE) begin
				o_hrdata <= {31'h0, src_fwd};
			end else begin
				o_hrdata <= '0;
			end
		end
	end

	// R3: source and tap choice
	assign use_low = low_clk_prescale_sel_r | (i_op_mode == dvo_pkg::MODE_SLOW) |
		(i_op_mode == dvo_pkg::MODE_SLOW_SLEEP);
	assign gear_idx = dvo_pkg::GEAR_TOP_TAP - {2'b00, divout_freq_sel_r};
	assign low_idx  = dvo_pkg::LOW_TOP_TAP - {1'b0, divout_freq_sel_r};
	// R11: reserved code on the low source
	assign sel_reserved = use_low & (divout_freq_sel_r == dvo_pkg::SEL_RESERVED);
	// R10: source swaps instantly, so the wave may glitch on mode changes
	assign tap = use_low ? low_cnt[low_idx] : gear_cnt[gear_idx];

	// R1: tap drives the pin; R2: R8: R9: a cleared enable forces high one clock edge later, not at once
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_divider_out_pin_n <= 1'b1;
		end else if (!divout_enable_r || sel_reserved) begin
			o_divider_out_pin_n <= 1'b1;
		end else begin
			o_divider_out_pin_n <= ~tap;
		end
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	disabled_pin_high_a: assert property (!divout_enable_r |=> o_divider_out_pin_n) // R2
		else $error("pin not high while disabled");
	sw_clear_stop_a: assert property (wr_ctrl && !i_hwdata[dvo_pkg::EN_BIT] |=> ##1 o_divider_out_pin_n) // R9
		else $error("pin not high after software clear");
	deep_clears_en_a: assert property (deep_entry |=> !divout_enable_r ##1 o_divider_out_pin_n) // R4
		else $error("low-power entry did not clear enable");
	deep_keeps_sel_a: assert property (deep_entry && !wr_ctrl |=> $stable(divout_freq_sel_r)) // R4
		else $error("select changed on low-power entry");
	reserved_idle_a: assert property (sel_reserved |=> o_divider_out_pin_n) // R11
		else $error("pin toggled with reserved code");
	wave_follows_a: assert property (divout_enable_r && !sel_reserved |=> o_divider_out_pin_n == !$past(tap)) // R1
		else $error("pin does not follow the tap");
	gear_tap_a: assert property (!use_low && divout_freq_sel_r == 2'h0 |-> tap == gear_cnt[4'hB]) // R3
		else $error("wrong gear tap");
	read_upper_zero_a: assert property (addr_phase && !i_hwrite && i_haddr == dvo_pkg::ADDR_CONTROL
		|=> o_hrdata[31:3] == 29'h0) // R6
		else $error("upper control bits not zero");
	chain_runs_a: assert property (i_gear_tick |=> gear_cnt == $past(gear_cnt) + 1'b1) // R7
		else $error("gear chain stalled");
	write_lands_a: assert property (wr_ctrl && !deep_entry |=> divout_enable_r == $past(i_hwdata[dvo_pkg::EN_BIT]) &&
		divout_freq_sel_r == $past(i_hwdata[1:0])) // R1
		else $error("control write lost");

	// taps per code, written from the divide ratios rather than the index arithmetic
	gear_code1_a: assert property (!use_low && divout_freq_sel_r == 2'h1 // R3
		|-> tap == gear_cnt[4'hA])
		else $error("gear tap wrong for code 1");

	gear_code2_a: assert property (!use_low && divout_freq_sel_r == 2'h2 // R3
		|-> tap == gear_cnt[4'h9])
		else $error("gear tap wrong for code 2");

	gear_code3_a: assert property (!use_low && divout_freq_sel_r == 2'h3 // R3
		|-> tap == gear_cnt[4'h8])
		else $error("gear tap wrong for code 3");

	low_code0_a: assert property (use_low && divout_freq_sel_r == 2'h0 // R3
		|-> tap == low_cnt[3'h4])
		else $error("low tap wrong for code 0");

	low_code1_a: assert property (use_low && divout_freq_sel_r == 2'h1 // R3
		|-> tap == low_cnt[3'h3])
		else $error("low tap wrong for code 1");

	low_code2_a: assert property (use_low && divout_freq_sel_r == 2'h2 // R3
		|-> tap == low_cnt[3'h2])
		else $error("low tap wrong for code 2");

	// source choice follows mode and prescale select
	slow_uses_low_a: assert property (i_op_mode == dvo_pkg::MODE_SLOW // R3
		|-> use_low)
		else $error("slow mode not on low clock");

	slow_sleep_low_a: assert property (i_op_mode == dvo_pkg::MODE_SLOW_SLEEP // R3
		|-> use_low)
		else $error("slow sleep mode not on low clock");

	normal_uses_gear_a: assert property ((i_op_mode == dvo_pkg::MODE_NORMAL || i_op_mode == dvo_pkg::MODE_IDLE) && // R3
		!low_clk_prescale_sel_r |-> !use_low)
		else $error("normal mode not on gear clock");

	prescale_low_a: assert property (low_clk_prescale_sel_r // R5
		|-> use_low)
		else $error("prescale select ignored");

	gear_no_reserved_a: assert property (!use_low // R11
		|-> !sel_reserved)
		else $error("code 11 treated as reserved on gear clock");

	// the chain keeps counting whatever the enable says
	low_chain_runs_a: assert property (i_low_freq_tick // R7
		|=> low_cnt == $past(low_cnt) + 1'b1)
		else $error("low chain stalled");

	low_chain_holds_a: assert property (!i_low_freq_tick // R7
		|=> $stable(low_cnt))
		else $error("low chain moved without a tick");

	chain_while_off_a: assert property (!divout_enable_r && i_low_freq_tick // R7
		|=> low_cnt != $past(low_cnt))
		else $error("chain stopped while disabled");

	pin_falls_enabled_a: assert property ($fell(o_divider_out_pin_n) // R1
		|-> $past(divout_enable_r) && !$past(sel_reserved))
		else $error("pin fell while disabled");

	// register bus
	src_write_lands_a: assert property (wr_src // R3
		|=> low_clk_prescale_sel_r == $past(i_hwdata[dvo_pkg::PRESCALE_BIT]))
		else $error("source write lost");

	ctrl_read_data_a: assert property (addr_phase && !i_hwrite && i_haddr == dvo_pkg::ADDR_CONTROL && !wr_ctrl // R6
		|=> o_hrdata[7:0] == $past({5'h00, divout_enable_r, divout_freq_sel_r}))
		else $error("control read data wrong");

	src_read_upper_a: assert property (addr_phase && !i_hwrite && i_haddr == dvo_pkg::ADDR_SOURCE // R6
		|=> o_hrdata[31:1] == 31'h0)
		else $error("source upper bits not zero");

	unmapped_zero_a: assert property (addr_phase && !i_hwrite && i_haddr != dvo_pkg::ADDR_CONTROL && // R6
		i_haddr != dvo_pkg::ADDR_SOURCE |=> o_hrdata == 32'h0)
		else $error("unmapped read not zero");

	rdata_holds_a: assert property (!(addr_phase && !i_hwrite) // R6
		|=> $stable(o_hrdata))
		else $error("read data changed without a read");

	// register state only moves on its own events
	mode_tracks_a: assert property (1'b1 // R4
		|=> mode_prev_r == $past(i_op_mode))
		else $error("mode history lost");

	deep_beats_write_a: assert property (deep_entry && wr_ctrl // R4
		|=> !divout_enable_r)
		else $error("write won over low-power entry");

	sel_only_written_a: assert property (!wr_ctrl // R4
		|=> $stable(divout_freq_sel_r))
		else $error("select changed without a write");

	prescale_only_written_a: assert property (!wr_src // R3
		|=> $stable(low_clk_prescale_sel_r))
		else $error("prescale changed without a write");

	enable_rise_write_a: assert property ($rose(divout_enable_r) // R1
		|-> $past(wr_ctrl) && $past(i_hwdata[dvo_pkg::EN_BIT]))
		else $error("enable set without a write");
endmodule : dvo_top

/* verification/dvo_buzzer_model.sv */
// buzzer-like load that times the active-low divider pin
`timescale 1ns/1ps
module dvo_buzzer_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_pin_n,
	output logic [31:0]      o_period,
	output logic [31:0]      o_low_w,
	output logic [31:0]      o_falls
);
	logic        last_r;
	logic [31:0] cnt_r;
	initial begin
		last_r = 1'b1;
		cnt_r = 32'h0;
		o_period = 32'h0;
		o_low_w = 32'h0;
		o_falls = 32'h0;
	end
	// a buzzer reacts to edges only, so the period is timed fall to fall
	always @(posedge i_clk_sys) begin
		last_r <= i_pin_n;
		cnt_r <= cnt_r + 32'h1;
		if (last_r === 1'b1 && i_pin_n === 1'b0) begin
			o_period <= cnt_r;
			o_falls <= o_falls + 32'h1;
			cnt_r <= 32'h1;
		end
		if (last_r === 1'b0 && i_pin_n === 1'b1)
			o_low_w <= cnt_r;
	end
endmodule : dvo_buzzer_model

/* verification/testbench.sv */
// register and waveform tests of the divider square-wave output
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, gtick = 1, ltick = 0;
	logic [7:0] haddr = 8'h0;
	logic [1:0] htrans = 2'h0, lcnt = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, per, loww, falls, rd, f0;
	logic hready, hresp, pin_n;
	dvo_pkg::dvo_mode_t mode = dvo_pkg::MODE_NORMAL;
	dvo_pkg::dvo_mode_t deep [3] = '{dvo_pkg::MODE_STOP, dvo_pkg::MODE_DEEP_IDLE, dvo_pkg::MODE_DEEP_SLEEP};
	int error_cnt = 0, n_tests = 0;
	always #12.5 clk = ~clk;
	// low clock is a tick every fourth system cycle
	always @(posedge clk) begin
		lcnt <= lcnt + 2'h1;
		ltick <= (lcnt == 2'h2);
	end
	dvo_top i_dvo_top (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .i_gear_tick(gtick), .i_low_freq_tick(ltick),
		.i_op_mode(mode), .o_divider_out_pin_n(pin_n));
	dvo_buzzer_model i_dvo_buzzer_model (.i_clk_sys(clk), .i_pin_n(pin_n), .o_period(per), .o_low_w(loww),
		.o_falls(falls));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= dvo_pkg::HTRANS_NONSEQ;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		chk("okay response", {31'h0, hresp}, 32'h0);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	// a select change may cut the first fall short, so the period is timed between falls two and three
	task automatic meas(input logic [31:0] exp);
		f0 = falls;
		while (falls < f0 + 32'h3) @(posedge clk);
		chk("period", per, exp);
		chk("low half", loww, exp >> 1);
	endtask : meas
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	initial begin
		#(25ns * 60000);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		xfer(1'b0, dvo_pkg::ADDR_CONTROL, 0, rd);
		chk("control reset", rd, 32'h0);
		chk("pin idle", {31'h0, pin_n}, 32'h1);
		wr(dvo_pkg::ADDR_CONTROL, 32'hFF);
		xfer(1'b0, dvo_pkg::ADDR_CONTROL, 0, rd);
		chk("control upper zero", rd, 32'h07);
		xfer(1'b0, 8'h40, 0, rd);
		chk("unmapped", rd, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(dvo_pkg::ADDR_CONTROL, 32'h4 | k);
			meas(32'h1 << (12 - k));
		end
		wr(dvo_pkg::ADDR_CONTROL, 32'h0);
		repeat (2) @(posedge clk);
		#1 chk("pin after clear", {31'h0, pin_n}, 32'h1);
		f0 = falls;
		repeat (600) @(posedge clk);
		chk("no falls disabled", falls, f0);
		wr(dvo_pkg::ADDR_SOURCE, 32'h1);
		for (int k = 0; k < 3; k++) begin
			wr(dvo_pkg::ADDR_CONTROL, 32'h4 | k);
			meas(32'h4 << (5 - k));
		end
		wr(dvo_pkg::ADDR_CONTROL, 32'h7);
		// a fall launched at the write edge is seen one edge later
		repeat (2) @(posedge clk);
		f0 = falls;
		repeat (300) @(posedge clk);
		chk("reserved falls", falls, f0);
		chk("reserved pin", {31'h0, pin_n}, 32'h1);
		wr(dvo_pkg::ADDR_SOURCE, 32'h0);
		mode <= dvo_pkg::MODE_SLOW;
		wr(dvo_pkg::ADDR_CONTROL, 32'h6);
		meas(32'h20);
		for (int m = 0; m < 3; m++) begin
			mode <= dvo_pkg::MODE_NORMAL;
			wr(dvo_pkg::ADDR_CONTROL, 32'h5);
			repeat (3) @(posedge clk);
			mode <= deep[m];
			repeat (2) @(posedge clk);
			#1 chk("pin deep", {31'h0, pin_n}, 32'h1);
			xfer(1'b0, dvo_pkg::ADDR_CONTROL, 0, rd);
			chk("deep clears enable", rd, 32'h1);
		end
		final_report();
	end
endmodule : testbench
